// ---- src/ccr_regs.svh ----
// Register offsets, field positions, reset values for the calibration bank
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define CCR_IDX_CTRL      8'h61
`define CCR_IDX_RING      8'h62
`define CCR_IDX_TIP       8'h63
`define CCR_IDX_DIFF      8'h64
`define CCR_IDX_COMMON    8'h65
`define CCR_IDX_ILIM      8'h66
`define CCR_IDX_MONITOR   8'h67
`define CCR_IDX_TRIM      8'h68

// ****************************************************************
// Field positions
// ****************************************************************
`define CCR_BIT_MON_ONE   4
`define CCR_BIT_MON_TWO   3
`define CCR_BIT_DAC       2
`define CCR_BIT_ADC       1
`define CCR_BIT_BALANCE   0
`define CCR_STEPS         5
`define CCR_TRIM_DAC_OFFSET_POSITIVE     3
`define CCR_TRIM_DAC_OFFSET_NEGATIVE     2
`define CCR_TRIM_ADC_OFFSET_POSITIVE     1
`define CCR_TRIM_ADC_OFFSET_NEGATIVE     0

// ****************************************************************
// Reset values
// ****************************************************************
`define CCR_RST_CTRL      5'h00
`define CCR_RST_GAIN      5'h10
`define CCR_RST_DAC_GAIN  5'h11
`define CCR_RST_ILIM      4'h8
`define CCR_RST_MONITOR   8'h00
`define CCR_RST_TRIM      4'h0

`endif

// ---- src/ccr_pkg.sv ----
// Types shared by the calibration control and result bank
package ccr_pkg;

    // Bus slave sequencing
    typedef enum logic [0:0] {
        CCR_BUS_READY,
        CCR_BUS_READ
    } ccr_bus_state_t;

    typedef logic [7:0] ccr_index_t;

endpackage : ccr_pkg

// ---- src/ccr_top.sv ----
// Calibration step control and trim result register bank on AHB-Lite
//
// Contract
// - First monitor calibration bit reads one while enabled or running.
// - Second monitor calibration bit reads one while enabled or running.
// - Writing one to audio DAC offset bit starts it; clears on finish.
// - Writing one to audio ADC offset bit starts it; clears on finish.
// - Writing one to balance bit starts balance calibration; clears after.
// - Five-bit RING mismatch code, resets 0x10, upper bits read zero.
// - Five-bit TIP mismatch code, resets 0x10, upper bits read zero.
// - Five-bit differential gain code, resets 0x11, upper bits zero.
// - Five-bit common-mode gain code, resets 0x11, upper bits zero.
// - Four-bit current limit code, resets 0x08, upper bits zero.
// - Monitor offset byte: code one high nibble, code two low.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "ccr_regs.svh"

module ccr_top
    import ccr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Calibration engine handshake, one bit per step
    output logic      [4:0]  cal_start,
    input  wire logic [4:0]  cal_done,
    // Step results delivered with cal_done
    input  wire logic [3:0]  monitor_one_result,
    input  wire logic [3:0]  monitor_two_result,
    input  wire logic [1:0]  dac_offset_result,
    input  wire logic [1:0]  adc_offset_result,
    // Gain results from the main calibration sequencer
    input  wire logic        ring_load,
    input  wire logic [4:0]  ring_result,
    input  wire logic        tip_load,
    input  wire logic [4:0]  tip_result,
    input  wire logic        diff_load,
    input  wire logic [4:0]  diff_result,
    input  wire logic        common_load,
    input  wire logic [4:0]  common_result,
    input  wire logic        ilim_load,
    input  wire logic [3:0]  ilim_result,
    // Trim codes to the analog front end
    output logic      [4:0]  ring_mismatch_code,
    output logic      [4:0]  tip_mismatch_code,
    output logic      [4:0]  diff_gain_code,
    output logic      [4:0]  common_gain_code,
    output logic      [3:0]  current_limit_code,
    output logic      [3:0]  monitor_offset_code_one,
    output logic      [3:0]  monitor_offset_code_two,
    output logic             dac_offset_positive,
    output logic             dac_offset_negative,
    output logic             adc_offset_positive,
    output logic             adc_offset_negative
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    // Word index of a byte address; out-of-window addresses give zero,
    // which no register uses, so they fall to the unmapped answer
    function automatic ccr_index_t addr_index(input logic [31:0] a);
        ccr_index_t idx;
        idx = 8'h00;
        if (a[31:10] == 22'h000000) begin
            idx = a[9:2];
        end
        return idx;
    endfunction : addr_index

    // ****************************************************************
    // State
    // ****************************************************************
    ccr_bus_state_t bus_state_reg;
    logic           hreadyout_reg;
    logic [31:0]    hrdata_reg;
    logic           wr_pend_reg;
    ccr_index_t     wr_idx_reg;
    ccr_index_t     rd_idx_reg;

    logic [4:0]     ctrl_reg;
    logic [4:0]     start_reg;
    logic [4:0]     ring_reg;
    logic [4:0]     tip_reg;
    logic [4:0]     diff_reg;
    logic [4:0]     common_reg;
    logic [3:0]     ilim_reg;
    logic [3:0]     mon_one_reg;
    logic [3:0]     mon_two_reg;
    logic [3:0]     trim_reg;

    logic           addr_ok;
    logic           wr_ctrl;
    logic [4:0]     step_end;
    logic [31:0]    rd_mux;

    // hsize and the low address bits are not decoded; only aligned
    // whole-word transfers are expected on this bank
    // Address phase is taken only while the bus shows ready
    assign addr_ok = hsel && htrans[1] && hready;

    // Software write strobe for the step control byte
    assign wr_ctrl = wr_pend_reg && (wr_idx_reg == `CCR_IDX_CTRL);

    // A step ends only if it was actually running; stray done is ignored
    assign step_end = cal_done & ctrl_reg;

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************

    // Reads take one wait state so the data always leave a flip-flop and
    // any write in the preceding data phase is already stored
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_state_reg <= CCR_BUS_READY;
            hreadyout_reg <= 1'b1;
            rd_idx_reg    <= 8'h00;
        end else begin
            unique case (bus_state_reg)
                CCR_BUS_READY: begin
                    if (addr_ok && !hwrite) begin
                        bus_state_reg <= CCR_BUS_READ;
                        hreadyout_reg <= 1'b0;
                        rd_idx_reg    <= addr_index(haddr);
                    end
                end
                CCR_BUS_READ: begin
                    bus_state_reg <= CCR_BUS_READY;
                    hreadyout_reg <= 1'b1;
                end
            endcase
        end
    end

    // Read data latched during the wait state, held until the next read
    always_ff @(posedge mclk) begin
        if (rst) begin
            hrdata_reg <= 32'h00000000;
        end else if (bus_state_reg == CCR_BUS_READ) begin
            hrdata_reg <= rd_mux;
        end
    end

    // Write address captured; data arrive in the following cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            if (addr_ok && hwrite) begin
                wr_idx_reg <= addr_index(haddr);
            end
        end
    end

    // Read multiplexer; reserved bits and unmapped words read zero
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (rd_idx_reg)
            `CCR_IDX_CTRL:    rd_mux[4:0] = ctrl_reg;
            `CCR_IDX_RING:    rd_mux[4:0] = ring_reg;
            `CCR_IDX_TIP:     rd_mux[4:0] = tip_reg;
            `CCR_IDX_DIFF:    rd_mux[4:0] = diff_reg;
            `CCR_IDX_COMMON:  rd_mux[4:0] = common_reg;
            `CCR_IDX_ILIM:    rd_mux[3:0] = ilim_reg;
            `CCR_IDX_MONITOR: rd_mux[7:0] = {mon_one_reg,
                                             mon_two_reg};
            `CCR_IDX_TRIM:    rd_mux[3:0] = trim_reg;
            default:          rd_mux = 32'h00000000;
        endcase
    end

    // ****************************************************************
    // Calibration step control
    // ****************************************************************

    // Each step bit is set by a software one and cleared by its own done;
    // a set in the same cycle as a done wins so no request is lost.
    // Writing zero does not abort a running step.
    for (genvar i = 0; i < `CCR_STEPS; i++) begin : g_step
        always_ff @(posedge mclk) begin
            if (rst) begin
                ctrl_reg[i] <= 1'(`CCR_RST_CTRL >> i);
            end else if (wr_ctrl && hwdata[i]) begin
                ctrl_reg[i] <= 1'b1;
            end else if (step_end[i]) begin
                ctrl_reg[i] <= 1'b0;
            end
        end

        // One-cycle start toward the engine, only from an idle step or one whose done arrives in the same cycle
        always_ff @(posedge mclk) begin
            if (rst) begin
                start_reg[i] <= 1'b0;
            end else begin
                start_reg[i] <= wr_ctrl && hwdata[i]
                                && (!ctrl_reg[i] || step_end[i]);
            end
        end
    end

    // ****************************************************************
    // Gain and current limit results
    // ****************************************************************

    // Hardware load beats a software write in the same cycle,
    // so a finished sequencer step is never undone by a stale write
    always_ff @(posedge mclk) begin
        if (rst) begin
            ring_reg <= `CCR_RST_GAIN;
        end else if (ring_load) begin
            ring_reg <= ring_result;
        end else if (wr_pend_reg && wr_idx_reg == `CCR_IDX_RING) begin
            ring_reg <= hwdata[4:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tip_reg <= `CCR_RST_GAIN;
        end else if (tip_load) begin
            tip_reg <= tip_result;
        end else if (wr_pend_reg && wr_idx_reg == `CCR_IDX_TIP) begin
            tip_reg <= hwdata[4:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            diff_reg <= `CCR_RST_DAC_GAIN;
        end else if (diff_load) begin
            diff_reg <= diff_result;
        end else if (wr_pend_reg && wr_idx_reg == `CCR_IDX_DIFF) begin
            diff_reg <= hwdata[4:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            common_reg <= `CCR_RST_DAC_GAIN;
        end else if (common_load) begin
            common_reg <= common_result;
        end else if (wr_pend_reg && wr_idx_reg == `CCR_IDX_COMMON) begin
            common_reg <= hwdata[4:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ilim_reg <= `CCR_RST_ILIM;
        end else if (ilim_load) begin
            ilim_reg <= ilim_result;
        end else if (wr_pend_reg && wr_idx_reg == `CCR_IDX_ILIM) begin
            ilim_reg <= hwdata[3:0];
        end
    end

    // ****************************************************************
    // Monitor converter offsets
    // ****************************************************************

    // Nibbles load independently so one step never disturbs the other;
    // the byte's reset value is split between the two nibble registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            mon_one_reg <= 4'(`CCR_RST_MONITOR >> 4);
        end else if (step_end[`CCR_BIT_MON_ONE]) begin
            mon_one_reg <= monitor_one_result;
        end else if (wr_pend_reg && wr_idx_reg == `CCR_IDX_MONITOR) begin
            mon_one_reg <= hwdata[7:4];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mon_two_reg <= 4'(`CCR_RST_MONITOR);
        end else if (step_end[`CCR_BIT_MON_TWO]) begin
            mon_two_reg <= monitor_two_result;
        end else if (wr_pend_reg && wr_idx_reg == `CCR_IDX_MONITOR) begin
            mon_two_reg <= hwdata[3:0];
        end
    end

    // ****************************************************************
    // Audio converter offset polarity trim
    // ****************************************************************

    // DAC pair and ADC pair follow their own steps; software may still
    // force any bit, which is how a board-level trim is patched in.
    // Later ifs win, so a step result beats a write in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            trim_reg <= `CCR_RST_TRIM;
        end else begin
            if (wr_pend_reg && wr_idx_reg == `CCR_IDX_TRIM) begin
                trim_reg <= hwdata[3:0];
            end
            if (step_end[`CCR_BIT_DAC]) begin
                trim_reg[`CCR_TRIM_DAC_OFFSET_POSITIVE:`CCR_TRIM_DAC_OFFSET_NEGATIVE]
                    <= dac_offset_result;
            end
            if (step_end[`CCR_BIT_ADC]) begin
                trim_reg[`CCR_TRIM_ADC_OFFSET_POSITIVE:`CCR_TRIM_ADC_OFFSET_NEGATIVE]
                    <= adc_offset_result;
            end
        end
    end

    // ****************************************************************
    // Outputs, all straight from flip-flops except hresp, which is tied to zero
    // ****************************************************************
    // Codes drive the front end directly; no gating after the flops
    assign hrdata                  = hrdata_reg;
    assign hreadyout               = hreadyout_reg;
    assign hresp                   = 1'b0;      // Always OKAY
    assign cal_start               = start_reg;
    assign ring_mismatch_code      = ring_reg;
    assign tip_mismatch_code       = tip_reg;
    assign diff_gain_code          = diff_reg;
    assign common_gain_code        = common_reg;
    assign current_limit_code      = ilim_reg;
    assign monitor_offset_code_one = mon_one_reg;
    assign monitor_offset_code_two = mon_two_reg;
    assign dac_offset_positive     = trim_reg[`CCR_TRIM_DAC_OFFSET_POSITIVE];
    assign dac_offset_negative     = trim_reg[`CCR_TRIM_DAC_OFFSET_NEGATIVE];
    assign adc_offset_positive     = trim_reg[`CCR_TRIM_ADC_OFFSET_POSITIVE];
    assign adc_offset_negative     = trim_reg[`CCR_TRIM_ADC_OFFSET_NEGATIVE];

endmodule : ccr_top

// ---- testbench/ccr_top_properties.sv ----
// Concurrent checks on the calibration bank's bus and trim ports
`timescale 1ns/1ps

module ccr_props (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [4:0]  cal_start,
    input wire logic        ring_load,
    input wire logic [4:0]  ring_result,
    input wire logic        tip_load,
    input wire logic [4:0]  tip_result,
    input wire logic        diff_load,
    input wire logic [4:0]  diff_result,
    input wire logic        common_load,
    input wire logic [4:0]  common_result,
    input wire logic        ilim_load,
    input wire logic [3:0]  ilim_result,
    input wire logic [4:0]  ring_mismatch_code,
    input wire logic [4:0]  tip_mismatch_code,
    input wire logic [4:0]  diff_gain_code,
    input wire logic [4:0]  common_gain_code,
    input wire logic [3:0]  current_limit_code
);
    // ****************************************************
    // Clocking and taken address phases
    // ****************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Both kinds of taken address phase
    wire rd_take = hsel && htrans[1] && hready && !hwrite;
    wire wr_take = hsel && htrans[1] && hready && hwrite;

    // ****************************************************
    // Properties
    // ****************************************************
    chk_read_wait: assert property (
        rd_take |=> !hreadyout ##1 hreadyout)
        else $error("Read wait state is not exactly one cycle");
    chk_write_nowait: assert property (
        wr_take |=> hreadyout)
        else $error("Write stalled the bus");
    chk_okay_resp: assert property (
        hresp == 1'b0)
        else $error("Response is not OKAY");
    chk_reserved_zero: assert property (
        $rose(hreadyout) |-> hrdata[31:8] == 24'h000000)
        else $error("Upper read data bits not zero");
    chk_start_pulse: assert property (
        |cal_start |=> (cal_start & $past(cal_start)) == 5'h00)
        else $error("Step start lasted more than one cycle");
    chk_reset_codes: assert property (
        $fell(rst) |-> ring_mismatch_code == 5'h10 &&
        tip_mismatch_code == 5'h10 && diff_gain_code == 5'h11 &&
        common_gain_code == 5'h11 && current_limit_code == 4'h8)
        else $error("Trim codes wrong after reset");
    chk_ring_load: assert property (
        ring_load |=> ring_mismatch_code == $past(ring_result))
        else $error("Ring code not loaded");
    chk_tip_load: assert property (
        tip_load ##1 1'b1 |-> tip_mismatch_code == $past(tip_result))
        else $error("Tip code not loaded");
    chk_diff_load: assert property (
        diff_load |=> diff_gain_code == $past(diff_result))
        else $error("Differential code not loaded");
    chk_common_load: assert property (
        common_load |=> common_gain_code == $past(common_result))
        else $error("Common-mode code not loaded");
    chk_ilim_load: assert property (
        ilim_load |=> current_limit_code == $past(ilim_result))
        else $error("Current limit code not loaded");
endmodule : ccr_props

bind ccr_top ccr_props u_props (
    .mclk, .rst, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .cal_start, .ring_load, .ring_result, .tip_load, .tip_result,
    .diff_load, .diff_result, .common_load, .common_result,
    .ilim_load, .ilim_result,
    .ring_mismatch_code, .tip_mismatch_code, .diff_gain_code,
    .common_gain_code, .current_limit_code
);

// ---- testbench/calibration_control_results_test.sv ----
// Self-checking bench for the calibration control and result bank
`timescale 1ns/1ps
`include "ccr_regs.svh"

module calibration_control_results_test;
    logic        mclk, rst, hsel, hwrite, hreadyout, hresp;
    logic [1:0]  htrans, dac_offset_result, adc_offset_result;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [4:0]  cal_start, cal_done, ring_result, tip_result;
    logic [4:0]  diff_result, common_result;
    logic [3:0]  monitor_one_result, monitor_two_result, ilim_result;
    logic        ring_load, tip_load, diff_load, common_load, ilim_load;
    logic [4:0]  ring_mismatch_code, tip_mismatch_code, diff_gain_code;
    logic [4:0]  common_gain_code;
    logic [3:0]  current_limit_code, monitor_offset_code_one;
    logic [3:0]  monitor_offset_code_two;
    logic        dac_offset_positive, dac_offset_negative;
    logic        adc_offset_positive, adc_offset_negative;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    wire         hready = hreadyout;
    // All trim outputs in one word for compact comparison
    wire  [35:0] codes = {ring_mismatch_code, tip_mismatch_code,
        diff_gain_code, common_gain_code, current_limit_code,
        monitor_offset_code_one, monitor_offset_code_two,
        dac_offset_positive, dac_offset_negative,
        adc_offset_positive, adc_offset_negative};

    ccr_top dut (
        .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .cal_start, .cal_done,
        .monitor_one_result, .monitor_two_result, .dac_offset_result,
        .adc_offset_result, .ring_load, .ring_result, .tip_load,
        .tip_result, .diff_load, .diff_result, .common_load,
        .common_result, .ilim_load, .ilim_result, .ring_mismatch_code,
        .tip_mismatch_code, .diff_gain_code, .common_gain_code,
        .current_limit_code, .monitor_offset_code_one,
        .monitor_offset_code_two, .dac_offset_positive,
        .dac_offset_negative, .adc_offset_positive, .adc_offset_negative
    );

    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // One AHB single transfer; the master never assumes a latency
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {22'h000000, idx, 2'b00};
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic check_reg(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 32'h00000000);
        cmp({4'h0, rd}, {28'h0000000, e});
    endtask : check_reg

    task automatic check_resets();
        logic [7:0] rv [0:7];
        rv = '{8'h00, 8'h10, 8'h10, 8'h11, 8'h11, 8'h08, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            check_reg(`CCR_IDX_CTRL + i[7:0], rv[i]);
        end
        cmp(codes, {5'h10, 5'h10, 5'h11, 5'h11, 4'h8, 12'h000});
    endtask : check_resets

    task automatic tally_and_finish();
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************************
    // Clock, hang guard and tests
    // ****************************************************
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Tests need a few hundred cycles, so this ceiling only trips on a hang
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        logic [7:0] pat [0:1];
        logic [7:0] mask [0:6];
        logic [7:0] idx, p;
        pat = '{8'hFF, 8'hA5};
        mask = '{8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'hFF, 8'h0F};
        rst = 1'b1;
        {hsel, hwrite, haddr, htrans, hwdata, cal_done} = '0;
        hsize = 3'h2;
        {monitor_one_result, monitor_two_result} = 8'h00;
        {dac_offset_result, adc_offset_result} = 4'h0;
        {ring_result, tip_result, diff_result, common_result} = 20'h00000;
        ilim_result = 4'h0;
        {ring_load, tip_load, diff_load, common_load, ilim_load} = 5'h00;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check_resets(); // Reset values
        // Reserved bits drop, written codes reach the trim outputs
        for (int k = 0; k < 2; k++) begin
            p = pat[k];
            for (int i = 0; i < 7; i++) begin
                idx = `CCR_IDX_RING + i[7:0];
                bus(1'b1, idx, {24'h000000, p});
                check_reg(idx, p & mask[i]);
            end
            cmp(codes, {{4{p[4:0]}}, p[3:0], p, p[3:0]});
        end
        bus(1'b1, 8'h60, 32'h000000FF);
        check_reg(8'h60, 8'h00); // Unmapped place
        check_reg(8'h69, 8'h00); // Unmapped place
        // Each step: one start, no restart while running, clear on done
        monitor_one_result <= 4'h9;
        monitor_two_result <= 4'h6;
        dac_offset_result  <= 2'b10;
        adc_offset_result  <= 2'b01;
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, `CCR_IDX_CTRL, 32'h00000001 << i);
            #1 cmp({31'h0, cal_start}, {31'h0, 5'h01 << i});
            @(posedge mclk);
            #1 cmp({31'h0, cal_start}, 36'h0);
            @(posedge mclk);
            bus(1'b1, `CCR_IDX_CTRL, 32'h00000001 << i);
            #1 cmp({31'h0, cal_start}, 36'h0);
            @(posedge mclk);
            check_reg(`CCR_IDX_CTRL, 8'h01 << i);
            cal_done <= 5'h01 << i;
            @(posedge mclk);
            cal_done <= 5'h00;
            check_reg(`CCR_IDX_CTRL, 8'h00);
        end
        cmp(codes, {{4{5'h05}}, 4'h5, 4'h9, 4'h6, 4'h9});
        check_reg(`CCR_IDX_MONITOR, 8'h96);
        check_reg(`CCR_IDX_TRIM, 8'h09);
        // A done pulse on an idle step must not load anything
        {monitor_one_result, monitor_two_result} <= 8'h00;
        {dac_offset_result, adc_offset_result} <= 4'h6;
        cal_done <= 5'h1F;
        @(posedge mclk);
        cal_done <= 5'h00;
        @(posedge mclk);
        cmp(codes, {{4{5'h05}}, 4'h5, 4'h9, 4'h6, 4'h9});
        // Sequencer loads of the gain results
        {ring_result, tip_result, diff_result} <= 15'h295A;
        common_result <= 5'h03;
        ilim_result <= 4'hC;
        {ring_load, tip_load, diff_load, common_load, ilim_load} <= 5'h1F;
        @(posedge mclk);
        {ring_load, tip_load, diff_load, common_load, ilim_load} <= 5'h00;
        @(posedge mclk);
        cmp(codes, {15'h295A, 5'h03, 4'hC, 4'h9, 4'h6, 4'h9});
        check_reg(`CCR_IDX_RING, 8'h0A);
        check_reg(`CCR_IDX_ILIM, 8'h0C);
        // Second reset in mid-run, with every step left running
        bus(1'b1, `CCR_IDX_CTRL, 32'h0000001F);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check_resets(); // Reset values
        tally_and_finish();
    end
endmodule : calibration_control_results_test
